/* File: rtl/tcw_defs.svh */
`ifndef TCW_DEFS_SVH
`define TCW_DEFS_SVH

// register byte offsets on the wishbone bus
`define TCW_OFS_CTRL 8'h00
`define TCW_OFS_COUNT 8'h04
`define TCW_OFS_COMPARE 8'h08
`define TCW_OFS_FLAGS 8'h0C
`define TCW_OFS_IRQEN 8'h10
`define TCW_OFS_STATUS 8'h14

// control register field positions
`define TCW_CTRL_MODE_LSB 0
`define TCW_CTRL_ACT_LSB 2
`define TCW_CTRL_CS_LSB 4
`define TCW_CTRL_FORCE_BIT 7
`define TCW_CTRL_DIR_BIT 8
`define TCW_CTRL_PORT_BIT 9
`define TCW_CTRL_SRC_BIT 10
`define TCW_CTRL_W 11

// flag and enable bit positions
`define TCW_FLAG_OVF_BIT 0
`define TCW_FLAG_CMP_BIT 1

// reset values
`define TCW_RST_CTRL 10'h000
`define TCW_RST_BYTE 8'h00

// prescale selections: tick masks of the divider
`define TCW_MASK_DIV1 10'h000
`define TCW_MASK_DIV8 10'h007
`define TCW_MASK_DIV32 10'h01F
`define TCW_MASK_DIV64 10'h03F
`define TCW_MASK_DIV128 10'h07F
`define TCW_MASK_DIV256 10'h0FF
`define TCW_MASK_DIV1024 10'h3FF

`endif

/* File: rtl/tcw_pkg.sv */
package tcw_pkg;

  // waveform mode encodings
  typedef enum logic [1:0] {
    TCW_NORMAL = 2'h0,
    TCW_PHASE = 2'h1,
    TCW_CLEAR = 2'h2,
    TCW_FAST = 2'h3
  } tcw_mode_t;

  // software control fields travelling together
  typedef struct packed {
    logic src_ext;
    logic port_out;
    logic pin_dir;
    logic [2:0] clock_select_field;
    logic [1:0] output_action_field;
    tcw_mode_t waveform_mode_field;
  } tcw_ctrl_t;

  // the two event flags
  typedef struct packed {
    logic compare_match_flag;
    logic overflow_flag;
  } tcw_flags_t;

endpackage

/* File: rtl/tcw_timer.sv */
`timescale 1ns/100ps
`include "tcw_defs.svh"
module tcw_timer
  import tcw_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int PRE_W = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ext_src_en_i,
  input wire logic ovf_serviced_i,
  input wire logic cmp_serviced_i,
  output logic ovf_irq_o,
  output logic cmp_irq_o,
  output logic pin_o,
  output logic pin_oe_n_o
);

  localparam logic [CNT_W-1:0] MAX_VAL = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] ZERO_VAL = {CNT_W{1'b0}};

  // ****************************************************************
  // bus slave
  // ****************************************************************

  logic ack_q;
  logic [31:0] dat_q;
  logic req;
  logic wr_en;
  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;
  logic wr_flags;
  logic wr_irqen;

  tcw_ctrl_t ctrl_q;
  tcw_flags_t flags_q;
  tcw_flags_t irqen_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] cmp_buf_q;
  logic [CNT_W-1:0] cmp_act_q;
  logic state_q;
  logic pin_q;
  logic oe_n_q;

  // a request is answered one cycle after it is seen; writes land with the ack
  assign req = cyc_i & stb_i;
  assign wr_en = req & we_i & ack_q & sel_i[0];
  assign wr_ctrl = wr_en & (adr_i == `TCW_OFS_CTRL);
  assign wr_count = wr_en & (adr_i == `TCW_OFS_COUNT);
  assign wr_compare = wr_en & (adr_i == `TCW_OFS_COMPARE);
  assign wr_flags = wr_en & (adr_i == `TCW_OFS_FLAGS);
  assign wr_irqen = wr_en & (adr_i == `TCW_OFS_IRQEN);
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ack pulses for one cycle, then drops even if the master still holds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // read data captured at the request edge; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req & ~ack_q) begin
      unique case (adr_i)
        `TCW_OFS_CTRL: dat_q <= {21'h00_0000, ctrl_q.src_ext, ctrl_q.port_out, ctrl_q.pin_dir,
          1'b0, ctrl_q.clock_select_field, ctrl_q.output_action_field,
          ctrl_q.waveform_mode_field};
        `TCW_OFS_COUNT: dat_q <= {24'h00_0000, count_q};
        `TCW_OFS_COMPARE: dat_q <= {24'h00_0000, cmp_buf_q};
        `TCW_OFS_FLAGS: dat_q <= {30'h0000_0000, flags_q};
        `TCW_OFS_IRQEN: dat_q <= {30'h0000_0000, irqen_q};
        `TCW_OFS_STATUS: dat_q <= {16'h0000, cmp_act_q, 7'h00, state_q};
        default: dat_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // control fields
  // ****************************************************************

  // mode, action and clock select take effect at once when written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `TCW_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q.waveform_mode_field <= tcw_mode_t'(dat_i[`TCW_CTRL_MODE_LSB +: 2]);
      ctrl_q.output_action_field <= dat_i[`TCW_CTRL_ACT_LSB +: 2];
      ctrl_q.clock_select_field <= dat_i[`TCW_CTRL_CS_LSB +: 3];
      if (sel_i[1]) begin
        ctrl_q.pin_dir <= dat_i[`TCW_CTRL_DIR_BIT];
        ctrl_q.port_out <= dat_i[`TCW_CTRL_PORT_BIT];
        ctrl_q.src_ext <= dat_i[`TCW_CTRL_SRC_BIT];
      end
    end
  end

  // interrupt enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irqen_q <= '0;
    end else if (wr_irqen) begin
      irqen_q <= dat_i[1:0];
    end
  end

  logic pwm_mode;
  logic force_hit;

  assign pwm_mode = ctrl_q.waveform_mode_field[0];
  // force strobe is never stored; it acts only in non-PWM modes
  assign force_hit = wr_ctrl & dat_i[`TCW_CTRL_FORCE_BIT] & ~pwm_mode;

  // ****************************************************************
  // prescaler
  // ****************************************************************

  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_mask;
  logic src_en;
  logic tick;

  // source is the system clock or the synchronous external enable
  assign src_en = ctrl_q.src_ext ? ext_src_en_i : 1'b1;

  // divider mask per clock select; select zero gives no tick at all
  always_comb begin
    pre_mask = `TCW_MASK_DIV1;
    unique case (ctrl_q.clock_select_field)
      3'h1: pre_mask = `TCW_MASK_DIV1;
      3'h2: pre_mask = `TCW_MASK_DIV8;
      3'h3: pre_mask = `TCW_MASK_DIV32;
      3'h4: pre_mask = `TCW_MASK_DIV64;
      3'h5: pre_mask = `TCW_MASK_DIV128;
      3'h6: pre_mask = `TCW_MASK_DIV256;
      3'h7: pre_mask = `TCW_MASK_DIV1024;
      default: pre_mask = `TCW_MASK_DIV1;
    endcase
  end

  // free-running divider advanced by each source pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= '0;
    end else if (src_en) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // tick is a one-cycle enable; stopped when clock select is zero
  assign tick = src_en & (ctrl_q.clock_select_field != 3'h0)
    & ((pre_q & pre_mask) == pre_mask);

  // ****************************************************************
  // counter and compare
  // ****************************************************************

  logic block_q;
  logic match;
  logic at_max;
  logic wrap;

  // a counter write blocks the next tick's match, running or stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  assign at_max = (count_q == MAX_VAL);
  assign match = tick & ~block_q & (count_q == cmp_act_q);
  // the counter passes max to zero on this tick, unless software writes
  assign wrap = tick & at_max & ~wr_count;

  // count sequence depends on mode and, in mode 2, on the compare match, never on the output action
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= ZERO_VAL;
    end else if (wr_count) begin
      count_q <= dat_i[CNT_W-1:0];
    end else if (tick) begin
      unique case (ctrl_q.waveform_mode_field)
        TCW_CLEAR: begin
          if (match) begin
            count_q <= ZERO_VAL;
          end else begin
            count_q <= count_q + 1'b1;
          end
        end
        TCW_FAST: count_q <= at_max ? ZERO_VAL : count_q + 1'b1;
        default: count_q <= count_q + 1'b1;
      endcase
    end
  end

  // software sees the buffer; non-PWM writes go straight to the comparator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_buf_q <= ZERO_VAL;
    end else if (wr_compare) begin
      cmp_buf_q <= dat_i[CNT_W-1:0];
    end
  end

  // active compare value: direct in non-PWM, loaded at wrap in PWM
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_act_q <= ZERO_VAL;
    end else if (wr_compare & ~pwm_mode) begin
      cmp_act_q <= dat_i[CNT_W-1:0];
    end else if (pwm_mode & tick & at_max) begin
      cmp_act_q <= cmp_buf_q;
    end
  end

  // ****************************************************************
  // flags and interrupt requests
  // ****************************************************************

  logic ovf_set;
  logic cmp_pend_q;
  logic cmp_set;

  // overflow: at the max-to-zero step in modes 0..2, on reaching max in mode 3
  always_comb begin
    if (ctrl_q.waveform_mode_field == TCW_FAST) begin
      ovf_set = tick & ~wr_count & (count_q == MAX_VAL - 1'b1);
    end else begin
      ovf_set = wrap;
    end
  end

  // match is remembered and raises the flag on the following tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_pend_q <= 1'b0;
    end else if (tick) begin
      cmp_pend_q <= match;
    end
  end

  assign cmp_set = tick & cmp_pend_q;

  // sticky flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else begin
      if (ovf_set) begin
        flags_q.overflow_flag <= 1'b1;
      end else if ((wr_flags & dat_i[`TCW_FLAG_OVF_BIT]) | ovf_serviced_i) begin
        flags_q.overflow_flag <= 1'b0;
      end
      if (cmp_set) begin
        flags_q.compare_match_flag <= 1'b1;
      end else if ((wr_flags & dat_i[`TCW_FLAG_CMP_BIT]) | cmp_serviced_i) begin
        flags_q.compare_match_flag <= 1'b0;
      end
    end
  end

  // one request per flag, each gated by its own enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_irq_o <= 1'b0;
      cmp_irq_o <= 1'b0;
    end else begin
      ovf_irq_o <= flags_q.overflow_flag & irqen_q.overflow_flag;
      cmp_irq_o <= flags_q.compare_match_flag & irqen_q.compare_match_flag;
    end
  end

  // ****************************************************************
  // waveform output
  // ****************************************************************

  logic state_d;
  logic [1:0] act;
  logic [1:0] hit_act;
  logic hit;

  assign act = ctrl_q.output_action_field;
  // a forced compare uses the action written together with the strobe
  assign hit_act = force_hit ? dat_i[`TCW_CTRL_ACT_LSB +: 2] : act;
  // a forced compare acts on the output only, never on flags or counter
  assign hit = match | force_hit;

  // next output state from the action in force at the match
  always_comb begin
    state_d = state_q;
    if (pwm_mode) begin
      if (ctrl_q.waveform_mode_field == TCW_FAST) begin
        if (wrap) begin
          if (act == 2'h2) begin
            state_d = 1'b1;
          end else if (act == 2'h3) begin
            state_d = 1'b0;
          end
        end
        if (match) begin
          unique case (act)
            2'h1: state_d = ~state_q;
            2'h2: state_d = 1'b0;
            2'h3: state_d = 1'b1;
            default: state_d = state_q;
          endcase
        end
      end
    end else if (hit) begin
      unique case (hit_act)
        2'h1: state_d = ~state_q;
        2'h2: state_d = 1'b0;
        2'h3: state_d = 1'b1;
        default: state_d = state_q;
      endcase
    end
  end

  // internal output state; untouched by mode changes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // pin: override when action nonzero in any mode; direction bit enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      pin_q <= (act != 2'h0) ? state_q : ctrl_q.port_out;
      oe_n_q <= ~ctrl_q.pin_dir;
    end
  end

  assign pin_o = pin_q;
  assign pin_oe_n_o = oe_n_q;

endmodule // tcw_timer

/* File: sim/tcw_timer_bench.sv */
`timescale 1ns/100ps
`include "tcw_defs.svh"
module tcw_timer_bench;
  // ********
  // design and clock
  // ********
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic ext_src_en_i = 1'b0;
  logic ovf_serviced_i = 1'b0;
  logic cmp_serviced_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic [31:0] cnt;
  logic ack_o;
  logic ovf_irq_o;
  logic cmp_irq_o;
  logic pin_o;
  logic pin_oe_n_o;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [1:0] acts [6] = '{2'h1, 2'h1, 2'h3, 2'h0, 2'h2, 2'h3};
  logic sts [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  int divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  tcw_timer tcw_timer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ext_src_en_i(ext_src_en_i), .ovf_serviced_i(ovf_serviced_i),
    .cmp_serviced_i(cmp_serviced_i), .ovf_irq_o(ovf_irq_o), .cmp_irq_o(cmp_irq_o),
    .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o)
  );
  // clock and hang ceiling
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  // ********
  // tasks
  // ********
  task automatic close_out();
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(nm, rd, exp);
  endtask
  // control write, pin always an output
  task automatic ctl(input logic [1:0] m, input logic [1:0] ac, input logic [2:0] cs,
                     input logic f, input logic p, input logic s);
    wb(1'b1, `TCW_OFS_CTRL, {21'h0, s, p, 1'b1, f, cs, ac, m}, 4'h3);
  endtask
  task automatic near(input string nm, input logic [31:0] seen, input int exp);
    chk(nm, 32'(seen + 1 >= exp && seen <= exp + 1), 32'h1);
  endtask
  // ********
  // main sequence
  // ********
  initial begin
    run(20);
    rst_i <= 1'b0;
    run(1);
    chk("oe_rst", 32'(pin_oe_n_o), 32'h1);
    foreach (offs[i]) rdc("reset", offs[i], 32'h0);
    wr(8'h18, 32'hFF);
    rdc("unmapped", 8'h18, 32'h0);
    wr(`TCW_OFS_COUNT, 32'h5A);
    run(20);
    rdc("stopped", `TCW_OFS_COUNT, 32'h5A);
    // a forced compare with action zero leaves the state at zero; a byte-0-only write keeps the pin an input
    wb(1'b1, `TCW_OFS_CTRL, 32'h80, 4'h1);
    rdc("pre_state", `TCW_OFS_STATUS, 32'h0);
    chk("oe_pre", 32'(pin_oe_n_o), 32'h1);
    for (int i = 0; i < 6; i++) begin
      ctl(2'h0, acts[i], 3'h0, 1'b1, 1'b0, 1'b0);
      rdc("force", `TCW_OFS_STATUS, {31'h0, sts[i]});
      chk("pin", 32'(pin_o), 32'(acts[i] != 2'h0 && sts[i]));
    end
    rdc("ctrl_rd", `TCW_OFS_CTRL, 32'h10C);
    rdc("force_cnt", `TCW_OFS_COUNT, 32'h5A);
    rdc("force_flg", `TCW_OFS_FLAGS, 32'h0);
    ctl(2'h3, 2'h0, 3'h0, 1'b0, 1'b1, 1'b0);
    rdc("mode_keep", `TCW_OFS_STATUS, 32'h1);
    chk("port", 32'(pin_o), 32'h1);
    ctl(2'h2, 2'h1, 3'h0, 1'b0, 1'b0, 1'b0);
    wr(`TCW_OFS_COMPARE, 32'h20);
    wr(`TCW_OFS_FLAGS, 32'h3);
    wr(`TCW_OFS_COUNT, 32'h20);
    ctl(2'h2, 2'h1, 3'h1, 1'b0, 1'b0, 1'b0);
    run(60);
    ctl(2'h2, 2'h1, 3'h0, 1'b0, 1'b0, 1'b0);
    wb(1'b0, `TCW_OFS_COUNT, 32'h0, 4'hF);
    chk("blocked", 32'(rd > 32'h20 && rd < 32'h70), 32'h1);
    rdc("no_match", `TCW_OFS_FLAGS, 32'h0);
    rdc("state", `TCW_OFS_STATUS, 32'h2001);
    ctl(2'h2, 2'h1, 3'h1, 1'b0, 1'b0, 1'b0);
    run(400);
    ctl(2'h2, 2'h1, 3'h0, 1'b0, 1'b0, 1'b0);
    wb(1'b0, `TCW_OFS_COUNT, 32'h0, 4'hF);
    chk("ctc_top", 32'(rd <= 32'h20), 32'h1);
    rdc("ctc_flg", `TCW_OFS_FLAGS, 32'h3);
    ctl(2'h2, 2'h3, 3'h0, 1'b1, 1'b0, 1'b0);
    ctl(2'h2, 2'h1, 3'h0, 1'b0, 1'b0, 1'b0);
    wr(`TCW_OFS_COUNT, 32'h1F);
    ctl(2'h2, 2'h1, 3'h1, 1'b0, 1'b0, 1'b0);
    run(8);
    ctl(2'h2, 2'h1, 3'h0, 1'b0, 1'b0, 1'b0);
    rdc("toggle", `TCW_OFS_STATUS, 32'h2000);
    wr(`TCW_OFS_IRQEN, 32'h3);
    run(1);
    chk("irq_ovf", 32'(ovf_irq_o), 32'h1);
    chk("irq_cmp", 32'(cmp_irq_o), 32'h1);
    ovf_serviced_i <= 1'b1;
    run(1);
    ovf_serviced_i <= 1'b0;
    run(2);
    chk("irq_ovf", 32'(ovf_irq_o), 32'h0);
    chk("irq_cmp", 32'(cmp_irq_o), 32'h1);
    wr(`TCW_OFS_FLAGS, 32'h2);
    rdc("w1c", `TCW_OFS_FLAGS, 32'h0);
    wr(`TCW_OFS_IRQEN, 32'h0);
    ctl(2'h3, 2'h2, 3'h0, 1'b0, 1'b0, 1'b0);
    wr(`TCW_OFS_COMPARE, 32'h80);
    rdc("buf", `TCW_OFS_COMPARE, 32'h80);
    rdc("active", `TCW_OFS_STATUS, 32'h2000);
    for (int a = 2; a < 4; a++) begin
      ctl(2'h3, 2'(a), 3'h1, 1'b0, 1'b0, 1'b0);
      run(300);
      ctl(2'h3, 2'(a), 3'h0, 1'b0, 1'b0, 1'b0);
      wb(1'b0, `TCW_OFS_COUNT, 32'h0, 4'hF);
      cnt = rd;
      rdc("pwm", `TCW_OFS_STATUS, {16'h0, 8'h80, 7'h0, (cnt <= 32'h80) ^ (a == 3)});
      chk("pwm_pin", 32'(pin_o), 32'((cnt <= 32'h80) ^ (a == 3)));
    end
    rdc("pwm_flg", `TCW_OFS_FLAGS, 32'h3);
    cmp_serviced_i <= 1'b1;
    run(1);
    cmp_serviced_i <= 1'b0;
    rdc("serviced", `TCW_OFS_FLAGS, 32'h1);
    ctl(2'h0, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    wr(`TCW_OFS_FLAGS, 32'h3);
    wr(`TCW_OFS_COUNT, 32'hF0);
    ctl(2'h0, 2'h0, 3'h1, 1'b0, 1'b0, 1'b0);
    run(40);
    ctl(2'h0, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    wb(1'b0, `TCW_OFS_COUNT, 32'h0, 4'hF);
    chk("wrap", 32'(rd > 32'h10 && rd < 32'h40), 32'h1);
    rdc("ovf", `TCW_OFS_FLAGS, 32'h1);
    for (int i = 1; i < 8; i++) begin
      wr(`TCW_OFS_COUNT, 32'h0);
      ctl(2'h0, 2'h0, 3'(i), 1'b0, 1'b0, 1'b0);
      run(4 * divs[i]);
      ctl(2'h0, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0);
      wb(1'b0, `TCW_OFS_COUNT, 32'h0, 4'hF);
      near("prescale", rd, (4 * divs[i] + 3) / divs[i]);
    end
    wr(`TCW_OFS_COUNT, 32'h0);
    ctl(2'h0, 2'h0, 3'h1, 1'b0, 1'b0, 1'b1);
    run(30);
    ext_src_en_i <= 1'b1;
    run(10);
    ext_src_en_i <= 1'b0;
    run(2);
    ctl(2'h0, 2'h0, 3'h0, 1'b0, 1'b0, 1'b1);
    wb(1'b0, `TCW_OFS_COUNT, 32'h0, 4'hF);
    near("ext_src", rd, 10);
    close_out();
  end
endmodule // tcw_timer_bench

bind tcw_timer tcw_props tcw_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .ext_src_en_i(ext_src_en_i), .ovf_serviced_i(ovf_serviced_i),
  .cmp_serviced_i(cmp_serviced_i), .ovf_irq_o(ovf_irq_o), .cmp_irq_o(cmp_irq_o),
  .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o)
);

/* File: sim/tcw_timer_properties.sv */
`timescale 1ns/100ps
module tcw_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic ext_src_en_i,
  input wire logic ovf_serviced_i,
  input wire logic cmp_serviced_i,
  input wire logic ovf_irq_o,
  input wire logic cmp_irq_o,
  input wire logic pin_o,
  input wire logic pin_oe_n_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ********
  // bus shapes
  // ********
  logic ctrl_ack;
  // control write being acknowledged, upper byte enabled
  assign ctrl_ack = cyc_i && stb_i && ack_o && we_i && sel_i[1] && adr_i == 8'h00;
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_wr_ack(logic [7:0] a);
    cyc_i && stb_i && ack_o && we_i && sel_i[0] && adr_i == a;
  endsequence
  // ********
  // properties
  // ********
  property p_ack_next;
    s_req |=> ack_o;
  endproperty
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  property p_ack_cause;
    ack_o |-> $past(cyc_i && stb_i && !ack_o);
  endproperty
  property p_unmapped;
    s_req ##0 (!we_i && adr_i >= 8'h18) |=> dat_o == 32'h0;
  endproperty
  property p_ctrl_rd;
    s_req ##0 (!we_i && adr_i == 8'h00) |=> dat_o[31:11] == 21'h0 && !dat_o[7];
  endproperty
  property p_oe_follow;
    s_wr_ack(8'h00) ##0 ctrl_ack |-> ##2 pin_oe_n_o == !$past(dat_i[8], 2);
  endproperty
  property p_oe_hold;
    !$past(rst_i) && $changed(pin_oe_n_o) |-> $past(ctrl_ack, 2);
  endproperty
  property p_port_val;
    s_wr_ack(8'h00) ##0 (ctrl_ack && dat_i[3:2] == 2'h0) |-> ##2 pin_o == $past(dat_i[9], 2);
  endproperty
  property p_irq_off;
    s_wr_ack(8'h10) ##0 (dat_i[1:0] == 2'h0) |-> ##2 !ovf_irq_o && !cmp_irq_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("strobe bit reads one");
  a_oe_follow: assert property (p_oe_follow) else $error("enable not from direction");
  a_oe_hold: assert property (p_oe_hold) else $error("enable moved alone");
  a_port_val: assert property (p_port_val) else $error("port value not on pin");
  a_irq_off: assert property (p_irq_off) else $error("request while masked");
endmodule // tcw_props
